/* rtl/hldc_pkg.sv */
package hldc_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DAC = 8'h04;
	localparam logic [7:0] OFS_TRIP = 8'h08;
	localparam logic [7:0] OFS_LOCK = 8'h0C;
	localparam logic [7:0] OFS_DIV1 = 8'h10;
	localparam logic [7:0] OFS_DIV2R = 8'h14;
	localparam logic [7:0] OFS_DIV2N = 8'h18;
	localparam logic [7:0] OFS_PIN = 8'h1C;
	localparam logic [7:0] OFS_STAT = 8'h20;
	// ****************************************
	// field positions
	// ****************************************
	localparam int CT_FORCE = 0;
	localparam int CT_MODE_LO = 1;
	localparam int CT_LOSS_OFF = 3;
	localparam int CT_RAIL_EN = 4;
	localparam int CT_TRACK = 5;
	localparam int CT_MANDAC = 6;
	localparam int CT_AUTOEXIT = 7;
	localparam int CT_DOUBLER = 8;
	localparam int CT_ZDELAY = 9;
	localparam int HI_LO = 16;
	localparam int PIN_HO_LO = 4;
	localparam int PIN_LVL_LD = 8;
	localparam int PIN_LVL_HO = 9;
	localparam int ST_HOLD = 0;
	localparam int ST_LD1 = 1;
	localparam int ST_LD2 = 2;
	localparam int ST_LOW = 3;
	localparam int ST_HIGH = 4;
	localparam int ST_RAIL = 5;
	localparam int ST_DLOCK = 6;
	// ****************************************
	// widths, limits, reset values
	// ****************************************
	localparam int DAC_W = 10;
	localparam int ERR_W = 16;
	localparam int DIV1_W = 14;
	localparam int DIV2R_W = 12;
	localparam int DIV2N_W = 18;
	localparam int PRE_W = 4;
	localparam logic [1:0] MODE_ENABLED = 2'h2;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [PRE_W-1:0] PRE_MIN = 4'h2;
	localparam logic [PRE_W-1:0] PRE_MAX = 4'h8;
	localparam logic [DAC_W-1:0] DAC_TOL = 10'h002;
	localparam logic [DAC_W-1:0] DAC_RESET = 10'h200;
	localparam logic [DAC_W-1:0] TRIP_LOW_RESET = 10'h000;
	localparam logic [DAC_W-1:0] TRIP_HIGH_RESET = 10'h3FF;
	localparam logic [ERR_W-1:0] WIN_RESET = 16'h0004;
	localparam logic [ERR_W-1:0] HOLD_CNT_RESET = 16'h0020;
	localparam logic [15:0] DAC_DIV_RESET = 16'h0001;
	localparam int PD1_MAX_MHZ = 40;
	localparam int DAC_STEP_UV = 3200;
	// ****************************************
	// status pin selections
	// ****************************************
	typedef enum logic [2:0] {
		SEL_LEVEL = 3'h0,
		SEL_LD1 = 3'h1,
		SEL_LD2 = 3'h2,
		SEL_LD_BOTH = 3'h3,
		SEL_HOLDOVER = 3'h4,
		SEL_RAIL = 3'h5,
		SEL_DAC_LOCKED = 3'h6
	} hldc_pin_sel_type;
	localparam logic [2:0] SEL_LD_RESET = 3'h1;
	localparam logic [2:0] SEL_HO_RESET = 3'h4;
	// ****************************************
	// holdover states
	// ****************************************
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_HOLDOVER = 2'h1
	} hldc_state_type;
endpackage

/* rtl/hldc_lock_detect.sv */
`timescale 1ns/1ps
module hldc_lock_detect #(
	parameter int ERR_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cmp_valid,
	input wire logic [ERR_W-1:0] phase_err,
	input wire logic [ERR_W-1:0] window,
	input wire logic [ERR_W-1:0] hold_count,
	output logic locked
);
	logic [ERR_W-1:0] count_ff;
	logic locked_ff;
	logic in_win;
	logic [ERR_W-1:0] nxt_count;

	assign in_win = phase_err < window;
	assign nxt_count = (count_ff == {ERR_W{1'b1}}) ? count_ff : count_ff + 1'b1;
	assign locked = locked_ff;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			count_ff <= '0;
		end else if (cmp_valid) begin
			count_ff <= in_win ? nxt_count : '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			locked_ff <= 1'b0;
		end else if (cmp_valid) begin
			if (!in_win) begin
				locked_ff <= 1'b0;
			end else if (nxt_count >= hold_count) begin
				locked_ff <= 1'b1;
			end
		end
	end
endmodule

/* rtl/hldc_dac_tracker.sv */
`timescale 1ns/1ps
module hldc_dac_tracker #(
	parameter int DAC_W = 10,
	parameter int DIV_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic pd_strobe,
	input wire logic track_en,
	input wire logic freeze,
	input wire logic [DIV_W-1:0] clk_div,
	input wire logic [DAC_W-1:0] tune_code,
	input wire logic [DAC_W-1:0] tol,
	input wire logic [DAC_W-1:0] reset_code,
	output logic [DAC_W-1:0] dac_count,
	output logic dac_locked
);
	logic [DIV_W-1:0] div_ff;
	logic [DAC_W-1:0] count_ff;
	logic tick;
	logic [DAC_W-1:0] diff;

	assign tick = pd_strobe && (div_ff + 1'b1 >= clk_div);
	assign diff = (tune_code > count_ff) ? tune_code - count_ff : count_ff - tune_code;
	assign dac_count = count_ff;
	assign dac_locked = track_en && (diff <= tol);

	// update tick at the phase detector rate over the divider
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			div_ff <= '0;
		end else if (pd_strobe) begin
			div_ff <= tick ? '0 : div_ff + 1'b1;
		end
	end

	// one code step per tick keeps the count within tolerance once acquired
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			count_ff <= reset_code;
		end else if (tick && track_en && !freeze) begin
			if (tune_code > count_ff) begin
				count_ff <= count_ff + 1'b1;
			end else if (tune_code < count_ff) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule

/* rtl/hldc_holdover_ctrl.sv */
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module hldc_holdover_ctrl (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hsel,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pd1_valid,
	input wire logic [hldc_pkg::ERR_W-1:0] pd1_phase_err,
	input wire logic pd2_valid,
	input wire logic [hldc_pkg::ERR_W-1:0] pd2_phase_err,
	input wire logic [hldc_pkg::DAC_W-1:0] tune_code,
	output logic loop1_cp_tristate,
	output logic [hldc_pkg::DAC_W-1:0] loop1_tune_node,
	output logic holdover,
	output logic loop1_lock_flag,
	output logic loop2_lock_flag,
	output logic lock_status_pin,
	output logic holdover_status_pin,
	output logic loop2_ref_doubler_en,
	output logic loop1_fb_from_mux,
	output logic [hldc_pkg::DIV1_W-1:0] loop1_r_div,
	output logic [hldc_pkg::DIV1_W-1:0] loop1_n_div,
	output logic [hldc_pkg::DIV2R_W-1:0] loop2_r_div,
	output logic [hldc_pkg::DIV2N_W-1:0] loop2_n_div,
	output logic [hldc_pkg::PRE_W-1:0] loop2_prescale
);
	localparam int DW = hldc_pkg::DAC_W;
	localparam int EW = hldc_pkg::ERR_W;

	// ****************************************
	// register storage
	// ****************************************
	logic force_holdover_ff;
	logic [1:0] holdover_mode_ff;
	logic loop1_lockloss_detect_off_ff;
	logic tune_rail_detect_en_ff;
	logic track_en_ff;
	logic manual_dac_en_ff;
	logic auto_exit_en_ff;
	logic doubler_ff;
	logic zero_delay_ff;
	logic [DW-1:0] manual_dac_value_ff;
	logic [DW-1:0] dac_lower_trip_ff;
	logic [DW-1:0] dac_upper_trip_ff;
	logic [EW-1:0] loop1_lock_window_ff;
	logic [EW-1:0] lock_hold_count_ff;
	logic [hldc_pkg::DIV1_W-1:0] div1_r_ff;
	logic [hldc_pkg::DIV1_W-1:0] div1_n_ff;
	logic [hldc_pkg::DIV2R_W-1:0] div2_r_ff;
	logic [hldc_pkg::PRE_W-1:0] prescale_ff;
	logic [hldc_pkg::DIV2N_W-1:0] div2_n_ff;
	logic [15:0] dac_clk_div_ff;
	logic [2:0] lock_pin_select_ff;
	logic [2:0] ho_pin_select_ff;
	logic lock_pin_level_ff;
	logic ho_pin_level_ff;

	// ****************************************
	// bus slave
	// ****************************************
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [31:0] hrdata_ff;
	logic [31:0] rd_word;
	logic addr_take;
	logic [31:0] stat_word;

	assign addr_take = hsel && hready && htrans[1];
	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= addr_take && hwrite && (haddr[31:8] == 24'h000000);
			wr_addr_ff <= haddr[7:0];
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		if (haddr[31:8] == 24'h000000) begin
			unique case (haddr[7:0])
				hldc_pkg::OFS_CTRL: begin
					rd_word[hldc_pkg::CT_FORCE] = force_holdover_ff;
					rd_word[hldc_pkg::CT_MODE_LO +: 2] = holdover_mode_ff;
					rd_word[hldc_pkg::CT_LOSS_OFF] = loop1_lockloss_detect_off_ff;
					rd_word[hldc_pkg::CT_RAIL_EN] = tune_rail_detect_en_ff;
					rd_word[hldc_pkg::CT_TRACK] = track_en_ff;
					rd_word[hldc_pkg::CT_MANDAC] = manual_dac_en_ff;
					rd_word[hldc_pkg::CT_AUTOEXIT] = auto_exit_en_ff;
					rd_word[hldc_pkg::CT_DOUBLER] = doubler_ff;
					rd_word[hldc_pkg::CT_ZDELAY] = zero_delay_ff;
				end
				hldc_pkg::OFS_DAC: begin
					rd_word[DW-1:0] = manual_dac_value_ff;
					rd_word[hldc_pkg::HI_LO +: 16] = dac_clk_div_ff;
				end
				hldc_pkg::OFS_TRIP: begin
					rd_word[DW-1:0] = dac_lower_trip_ff;
					rd_word[hldc_pkg::HI_LO +: DW] = dac_upper_trip_ff;
				end
				hldc_pkg::OFS_LOCK: begin
					rd_word[EW-1:0] = loop1_lock_window_ff;
					rd_word[hldc_pkg::HI_LO +: EW] = lock_hold_count_ff;
				end
				hldc_pkg::OFS_DIV1: begin
					rd_word[hldc_pkg::DIV1_W-1:0] = div1_r_ff;
					rd_word[hldc_pkg::HI_LO +: hldc_pkg::DIV1_W] = div1_n_ff;
				end
				hldc_pkg::OFS_DIV2R: begin
					rd_word[hldc_pkg::DIV2R_W-1:0] = div2_r_ff;
					rd_word[hldc_pkg::HI_LO +: hldc_pkg::PRE_W] = prescale_ff;
				end
				hldc_pkg::OFS_DIV2N: rd_word[hldc_pkg::DIV2N_W-1:0] = div2_n_ff;
				hldc_pkg::OFS_PIN: begin
					rd_word[2:0] = lock_pin_select_ff;
					rd_word[hldc_pkg::PIN_HO_LO +: 3] = ho_pin_select_ff;
					rd_word[hldc_pkg::PIN_LVL_LD] = lock_pin_level_ff;
					rd_word[hldc_pkg::PIN_LVL_HO] = ho_pin_level_ff;
				end
				hldc_pkg::OFS_STAT: rd_word = stat_word;
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hrdata_ff <= 32'h00000000;
		end else if (addr_take && !hwrite) begin
			hrdata_ff <= rd_word;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			force_holdover_ff <= 1'b0;
			holdover_mode_ff <= hldc_pkg::MODE_RESET;
			loop1_lockloss_detect_off_ff <= 1'b0;
			tune_rail_detect_en_ff <= 1'b0;
			track_en_ff <= 1'b0;
			manual_dac_en_ff <= 1'b0;
			auto_exit_en_ff <= 1'b0;
			doubler_ff <= 1'b0;
			zero_delay_ff <= 1'b0;
			manual_dac_value_ff <= hldc_pkg::DAC_RESET;
			dac_clk_div_ff <= hldc_pkg::DAC_DIV_RESET;
			dac_lower_trip_ff <= hldc_pkg::TRIP_LOW_RESET;
			dac_upper_trip_ff <= hldc_pkg::TRIP_HIGH_RESET;
			loop1_lock_window_ff <= hldc_pkg::WIN_RESET;
			lock_hold_count_ff <= hldc_pkg::HOLD_CNT_RESET;
			div1_r_ff <= '0;
			div1_n_ff <= '0;
			div2_r_ff <= '0;
			prescale_ff <= hldc_pkg::PRE_MIN;
			div2_n_ff <= '0;
			lock_pin_select_ff <= hldc_pkg::SEL_LD_RESET;
			ho_pin_select_ff <= hldc_pkg::SEL_HO_RESET;
			lock_pin_level_ff <= 1'b0;
			ho_pin_level_ff <= 1'b0;
		end else if (wr_pend_ff) begin
			unique case (wr_addr_ff)
				hldc_pkg::OFS_CTRL: begin
					force_holdover_ff <= hwdata[hldc_pkg::CT_FORCE];
					holdover_mode_ff <= hwdata[hldc_pkg::CT_MODE_LO +: 2];
					loop1_lockloss_detect_off_ff <= hwdata[hldc_pkg::CT_LOSS_OFF];
					tune_rail_detect_en_ff <= hwdata[hldc_pkg::CT_RAIL_EN];
					track_en_ff <= hwdata[hldc_pkg::CT_TRACK];
					manual_dac_en_ff <= hwdata[hldc_pkg::CT_MANDAC];
					auto_exit_en_ff <= hwdata[hldc_pkg::CT_AUTOEXIT];
					doubler_ff <= hwdata[hldc_pkg::CT_DOUBLER];
					zero_delay_ff <= hwdata[hldc_pkg::CT_ZDELAY];
				end
				hldc_pkg::OFS_DAC: begin
					manual_dac_value_ff <= hwdata[DW-1:0];
					dac_clk_div_ff <= hwdata[hldc_pkg::HI_LO +: 16];
				end
				hldc_pkg::OFS_TRIP: begin
					dac_lower_trip_ff <= hwdata[DW-1:0];
					dac_upper_trip_ff <= hwdata[hldc_pkg::HI_LO +: DW];
				end
				hldc_pkg::OFS_LOCK: begin
					loop1_lock_window_ff <= hwdata[EW-1:0];
					lock_hold_count_ff <= hwdata[hldc_pkg::HI_LO +: EW];
				end
				hldc_pkg::OFS_DIV1: begin
					div1_r_ff <= hwdata[hldc_pkg::DIV1_W-1:0];
					div1_n_ff <= hwdata[hldc_pkg::HI_LO +: hldc_pkg::DIV1_W];
				end
				hldc_pkg::OFS_DIV2R: begin
					div2_r_ff <= hwdata[hldc_pkg::DIV2R_W-1:0];
					prescale_ff <= hwdata[hldc_pkg::HI_LO +: hldc_pkg::PRE_W];
				end
				hldc_pkg::OFS_DIV2N: div2_n_ff <= hwdata[hldc_pkg::DIV2N_W-1:0];
				hldc_pkg::OFS_PIN: begin
					lock_pin_select_ff <= hwdata[2:0];
					ho_pin_select_ff <= hwdata[hldc_pkg::PIN_HO_LO +: 3];
					lock_pin_level_ff <= hwdata[hldc_pkg::PIN_LVL_LD];
					ho_pin_level_ff <= hwdata[hldc_pkg::PIN_LVL_HO];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// lock detectors and dac tracking
	// ****************************************
	logic ld1_raw;
	logic ld2_raw;
	logic [DW-1:0] dac_count;
	logic dac_locked;
	logic dac_low;
	logic dac_high;
	logic dac_rail;
	logic ld1_prev_ff;
	hldc_pkg::hldc_state_type state_ff;
	hldc_pkg::hldc_state_type nxt_state;

	// loop one detector keeps comparing during holdover
	hldc_lock_detect #(.ERR_W(EW)) u_ld1 (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.cmp_valid(pd1_valid),
		.phase_err(pd1_phase_err),
		.window(loop1_lock_window_ff),
		.hold_count(lock_hold_count_ff),
		.locked(ld1_raw)
	);

	hldc_lock_detect #(.ERR_W(EW)) u_ld2 (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.cmp_valid(pd2_valid),
		.phase_err(pd2_phase_err),
		.window(loop1_lock_window_ff),
		.hold_count(lock_hold_count_ff),
		.locked(ld2_raw)
	);

	hldc_dac_tracker #(.DAC_W(DW), .DIV_W(16)) u_track (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pd_strobe(pd1_valid),
		.track_en(track_en_ff),
		.freeze(state_ff == hldc_pkg::ST_HOLDOVER),
		.clk_div(dac_clk_div_ff),
		.tune_code(tune_code),
		.tol(hldc_pkg::DAC_TOL),
		.reset_code(hldc_pkg::DAC_RESET),
		.dac_count(dac_count),
		.dac_locked(dac_locked)
	);

	assign dac_low = tune_code < dac_lower_trip_ff;
	assign dac_high = tune_code > dac_upper_trip_ff;
	assign dac_rail = dac_low || dac_high;

	// ****************************************
	// holdover state machine
	// ****************************************
	logic mode_on;
	logic lock_lost;
	logic rail_trip;
	logic enter;
	logic leave;

	assign mode_on = holdover_mode_ff == hldc_pkg::MODE_ENABLED;
	assign lock_lost = ld1_prev_ff && !ld1_raw && !loop1_lockloss_detect_off_ff;
	assign rail_trip = tune_rail_detect_en_ff && track_en_ff && dac_rail;
	assign enter = force_holdover_ff || (mode_on && (lock_lost || rail_trip));
	assign leave = !force_holdover_ff && (!mode_on || (auto_exit_en_ff && ld1_raw));

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ld1_prev_ff <= 1'b0;
		end else begin
			ld1_prev_ff <= ld1_raw;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			hldc_pkg::ST_RUN: if (enter) nxt_state = hldc_pkg::ST_HOLDOVER;
			hldc_pkg::ST_HOLDOVER: if (leave) nxt_state = hldc_pkg::ST_RUN;
			default: nxt_state = hldc_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_ff <= hldc_pkg::ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	logic hold_nxt;
	logic ld2_keep_ff;
	logic ld2_keep_src;
	logic ld1_out_nxt;
	logic ld2_out_nxt;
	logic [DW-1:0] dac_nxt;
	logic holdover_ff;
	logic ld1_out_ff;
	logic ld2_out_ff;
	logic [DW-1:0] dac_out_ff;
	logic lock_pin_ff;
	logic ho_pin_ff;
	logic cfg_dbl_ff;
	logic cfg_fb_ff;
	logic [hldc_pkg::PRE_W-1:0] pre_ff;

	function automatic logic pin_mux(input logic [2:0] sel, input logic lvl, input logic l1,
		input logic l2, input logic ho, input logic rail, input logic dlk);
		logic r;
		r = lvl;
		unique case (sel)
			hldc_pkg::SEL_LEVEL: r = lvl;
			hldc_pkg::SEL_LD1: r = l1;
			hldc_pkg::SEL_LD2: r = l2;
			hldc_pkg::SEL_LD_BOTH: r = l1 && l2;
			hldc_pkg::SEL_HOLDOVER: r = ho;
			hldc_pkg::SEL_RAIL: r = rail;
			hldc_pkg::SEL_DAC_LOCKED: r = dlk;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign hold_nxt = nxt_state == hldc_pkg::ST_HOLDOVER;
	assign ld1_out_nxt = ld1_raw && !hold_nxt;
	assign ld2_keep_src = (state_ff == hldc_pkg::ST_RUN) ? ld2_raw : ld2_keep_ff;
	assign ld2_out_nxt = ld2_raw || (hold_nxt && ld2_keep_src);
	always_comb begin
		if (hold_nxt) begin
			dac_nxt = manual_dac_en_ff ? manual_dac_value_ff : dac_count;
		end else begin
			dac_nxt = track_en_ff ? dac_count : manual_dac_value_ff;
		end
	end

	// loop two lock latched on the clock of entry
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ld2_keep_ff <= 1'b0;
		end else if (state_ff == hldc_pkg::ST_RUN) begin
			ld2_keep_ff <= ld2_raw;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			holdover_ff <= 1'b0;
			ld1_out_ff <= 1'b0;
			ld2_out_ff <= 1'b0;
			dac_out_ff <= hldc_pkg::DAC_RESET;
		end else begin
			holdover_ff <= hold_nxt;
			ld1_out_ff <= ld1_out_nxt;
			ld2_out_ff <= ld2_out_nxt;
			dac_out_ff <= dac_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			lock_pin_ff <= 1'b0;
			ho_pin_ff <= 1'b0;
		end else begin
			lock_pin_ff <= pin_mux(lock_pin_select_ff, lock_pin_level_ff, ld1_out_nxt,
				ld2_out_nxt, hold_nxt, dac_rail, dac_locked);
			ho_pin_ff <= pin_mux(ho_pin_select_ff, ho_pin_level_ff, ld1_out_nxt,
				ld2_out_nxt, hold_nxt, dac_rail, dac_locked);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg_dbl_ff <= 1'b0;
			cfg_fb_ff <= 1'b0;
			pre_ff <= hldc_pkg::PRE_MIN;
		end else begin
			cfg_dbl_ff <= doubler_ff;
			cfg_fb_ff <= zero_delay_ff;
			if (prescale_ff < hldc_pkg::PRE_MIN) begin
				pre_ff <= hldc_pkg::PRE_MIN;
			end else if (prescale_ff > hldc_pkg::PRE_MAX) begin
				pre_ff <= hldc_pkg::PRE_MAX;
			end else begin
				pre_ff <= prescale_ff;
			end
		end
	end

	always_comb begin
		stat_word = 32'h00000000;
		stat_word[hldc_pkg::ST_HOLD] = holdover_ff;
		stat_word[hldc_pkg::ST_LD1] = ld1_out_ff;
		stat_word[hldc_pkg::ST_LD2] = ld2_out_ff;
		stat_word[hldc_pkg::ST_LOW] = dac_low;
		stat_word[hldc_pkg::ST_HIGH] = dac_high;
		stat_word[hldc_pkg::ST_RAIL] = dac_rail;
		stat_word[hldc_pkg::ST_DLOCK] = dac_locked;
		stat_word[hldc_pkg::HI_LO +: DW] = dac_count;
	end

	assign holdover = holdover_ff;
	assign loop1_cp_tristate = holdover_ff;
	assign loop1_lock_flag = ld1_out_ff;
	assign loop2_lock_flag = ld2_out_ff;
	assign loop1_tune_node = dac_out_ff;
	assign lock_status_pin = lock_pin_ff;
	assign holdover_status_pin = ho_pin_ff;
	assign loop2_ref_doubler_en = cfg_dbl_ff;
	assign loop1_fb_from_mux = cfg_fb_ff;
	assign loop1_r_div = div1_r_ff;
	assign loop1_n_div = div1_n_ff;
	assign loop2_r_div = div2_r_ff;
	assign loop2_n_div = div2_n_ff;
	assign loop2_prescale = pre_ff;
endmodule

/* testbench/hldc_chk_sva.sv */
`timescale 1ns/1ps
module hldc_chk (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic pd1_valid,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic holdover,
	input wire logic loop1_cp_tristate,
	input wire logic loop1_lock_flag,
	input wire logic loop2_lock_flag,
	input wire logic [3:0] loop2_prescale
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// loop two lock as seen in the first holdover cycle
	logic ho_d_ff;
	logic ld2_entry_ff;
	always_ff @(posedge sys_clk) begin
		ho_d_ff <= holdover;
		if (holdover && !ho_d_ff) begin
			ld2_entry_ff <= loop2_lock_flag;
		end
	end
	// ****************
	// assertions
	// ****************
	AST_TRI: assert property (holdover == loop1_cp_tristate)
		else $error("pump state differs from holdover");
	AST_LD1_LOW: assert property (holdover |-> !loop1_lock_flag)
		else $error("loop one lock high in holdover");
	AST_LD2_KEEP: assert property (holdover && ho_d_ff && ld2_entry_ff |-> loop2_lock_flag)
		else $error("loop two lock dropped in holdover");
	AST_ENTRY: assert property ($rose(holdover) |-> loop1_cp_tristate && !loop1_lock_flag)
		else $error("entry outputs late");
	AST_BUS: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
	AST_PRE: assert property (loop2_prescale >= 4'h2 && loop2_prescale <= 4'h8)
		else $error("prescaler out of range");
	AST_LD_RISE: assert property ($rose(loop1_lock_flag) && !$past(holdover)
		&& !$past(holdover, 2) |-> $past(pd1_valid, 2)) else $error("lock without compare");
	AST_LD_FALL: assert property ($fell(loop1_lock_flag) && !holdover
		|-> $past(pd1_valid, 2)) else $error("lock lost without compare");
	cover property ($rose(holdover));
	cover property ($fell(holdover));
	cover property ($rose(loop1_lock_flag));
endmodule
bind hldc_holdover_ctrl hldc_chk hldc_chk_i (.*);

/* testbench/hldc_host_model.sv */
`timescale 1ns/1ps
module hldc_host_model (
	input wire logic sys_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0] htrans = 2'h0,
	output logic hwrite = 1'b0,
	output logic [31:0] hwdata = 32'h0
);
	// ****************
	// single word transfer; exit and doubler setup come from the host
	// ****************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge sys_clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic sys_clk = 0;
	logic rst_b = 0;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic hwrite, hreadyout, hresp, hready;
	logic hsel = 1;
	logic [2:0] hsize = 3'h2;
	logic pd1_valid = 0;
	logic pd2_valid = 0;
	logic [15:0] pd1_phase_err = 16'h0;
	logic [15:0] pd2_phase_err = 16'h0;
	logic [9:0] tune_code = 10'h200;
	logic [9:0] loop1_tune_node;
	logic loop1_cp_tristate, holdover, loop1_lock_flag, loop2_lock_flag;
	logic lock_status_pin, holdover_status_pin, loop2_ref_doubler_en, loop1_fb_from_mux;
	logic [13:0] loop1_r_div, loop1_n_div;
	logic [11:0] loop2_r_div;
	logic [17:0] loop2_n_div;
	logic [3:0] loop2_prescale;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	assign hready = hreadyout;
	always #2.5 sys_clk = ~sys_clk;
	hldc_holdover_ctrl hldc_holdover_ctrl_i (.*);
	hldc_host_model hldc_host_model_i (.*);
	// ****************
	// helpers
	// ****************
	task report_and_stop;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			report_and_stop;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		hldc_host_model_i.xfer(1'b1, a, d, r);
		settle;
	endtask
	task rd(input logic [7:0] a);
		hldc_host_model_i.xfer(1'b0, a, 32'h0, r);
	endtask
	task pulse(input logic [15:0] e);
		@(posedge sys_clk);
		pd1_valid <= 1'b1;
		pd2_valid <= 1'b1;
		pd1_phase_err <= e;
		pd2_phase_err <= e;
		@(posedge sys_clk);
		pd1_valid <= 1'b0;
		pd2_valid <= 1'b0;
	endtask
	// ****************
	// scenarios
	// ****************
	task t_lock;
		#1;
		chk(loop1_tune_node, 32'h200);
		chk(loop2_prescale, 32'h2);
		wr(hldc_pkg::OFS_LOCK, 32'h0003_0004);
		repeat (2) pulse(16'h1);
		pulse(16'h4);
		repeat (2) pulse(16'h1);
		settle;
		chk(loop1_lock_flag, 32'h0);
		pulse(16'h1);
		settle;
		chk(loop1_lock_flag, 32'h1);
		chk(loop2_lock_flag, 32'h1);
		$display("lock test done");
	endtask
	task t_force;
		wr(hldc_pkg::OFS_DAC, 32'h0001_0155);
		wr(hldc_pkg::OFS_CTRL, 32'h61);
		chk(holdover, 32'h1);
		chk(loop1_cp_tristate, 32'h1);
		chk(loop1_lock_flag, 32'h0);
		chk(loop2_lock_flag, 32'h1);
		chk(holdover_status_pin, 32'h1);
		chk(loop1_tune_node, 32'h155);
		rd(hldc_pkg::OFS_STAT);
		chk(r & 32'h1, 32'h1);
		pulse(16'h4);
		settle;
		chk(loop2_lock_flag, 32'h1);
		wr(hldc_pkg::OFS_CTRL, 32'h0);
		chk(holdover, 32'h0);
		chk(loop1_cp_tristate, 32'h0);
		chk(loop2_lock_flag, 32'h0);
		repeat (3) pulse(16'h1);
		$display("force test done");
	endtask
	task t_loss;
		wr(hldc_pkg::OFS_CTRL, 32'h4);
		pulse(16'h4);
		settle;
		chk(holdover, 32'h1);
		chk(loop1_lock_flag, 32'h0);
		wr(hldc_pkg::OFS_CTRL, 32'h84);
		repeat (2) pulse(16'h1);
		settle;
		chk(holdover, 32'h1);
		pulse(16'h1);
		settle;
		chk(holdover, 32'h0);
		chk(loop1_lock_flag, 32'h1);
		$display("lock loss test done");
	endtask
	task t_rail;
		wr(hldc_pkg::OFS_TRIP, 32'h03FF_0100);
		@(posedge sys_clk);
		tune_code <= 10'h050;
		wr(hldc_pkg::OFS_CTRL, 32'h34);
		chk(holdover, 32'h1);
		rd(hldc_pkg::OFS_STAT);
		chk(r & 32'h38, 32'h28);
		wr(hldc_pkg::OFS_CTRL, 32'h0);
		chk(holdover, 32'h0);
		$display("rail test done");
	endtask
	task t_track;
		wr(hldc_pkg::OFS_DAC, 32'h0002_0155);
		@(posedge sys_clk);
		tune_code <= 10'h1FC;
		wr(hldc_pkg::OFS_CTRL, 32'h20);
		pulse(16'h1);
		settle;
		chk(loop1_tune_node, 32'h200);
		pulse(16'h1);
		settle;
		chk(loop1_tune_node, 32'h1FF);
		rd(hldc_pkg::OFS_STAT);
		chk(r & 32'h40, 32'h0);
		repeat (2) pulse(16'h1);
		settle;
		rd(hldc_pkg::OFS_STAT);
		chk(r & 32'h03FF_0040, 32'h01FE_0040);
		wr(hldc_pkg::OFS_CTRL, 32'h21);
		repeat (2) pulse(16'h1);
		settle;
		chk(loop1_tune_node, 32'h1FE);
		wr(hldc_pkg::OFS_CTRL, 32'h0);
		$display("tracking test done");
	endtask
	task t_pins;
		wr(hldc_pkg::OFS_PIN, 32'h143);
		chk(lock_status_pin, 32'h1);
		wr(hldc_pkg::OFS_PIN, 32'h100);
		chk(lock_status_pin, 32'h1);
		chk(holdover_status_pin, 32'h0);
		wr(hldc_pkg::OFS_PIN, 32'h0);
		chk(lock_status_pin, 32'h0);
		wr(hldc_pkg::OFS_PIN, 32'h52);
		chk(lock_status_pin, 32'h1);
		chk(holdover_status_pin, 32'h0);
		$display("pin test done");
	endtask
	task t_div;
		wr(hldc_pkg::OFS_CTRL, 32'h300);
		wr(hldc_pkg::OFS_DIV1, 32'h3FFF_3FFF);
		wr(hldc_pkg::OFS_DIV2R, 32'h0009_0002);
		wr(hldc_pkg::OFS_DIV2N, 32'h0003_FFFF);
		chk(loop2_ref_doubler_en, 32'h1);
		chk(loop1_fb_from_mux, 32'h1);
		chk({loop1_n_div, loop1_r_div}, 32'h0FFF_FFFF);
		chk(loop2_r_div, 32'h2);
		chk(loop2_n_div, 32'h3FFFF);
		chk(loop2_prescale, 32'h8);
		rd(8'h80);
		chk(r, 32'h0);
		$display("divider test done");
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_lock;
		t_force;
		t_loss;
		t_rail;
		t_track;
		t_pins;
		t_div;
		report_and_stop;
	end
endmodule
